// ==== mitc_defs.svh ====
// Purpose: constants for the instruction timing core
// Assumes: 16-bit instruction word, 13-bit program counter
// Notes: opcode field layout is local to this core
`ifndef MITC_DEFS_SVH
`define MITC_DEFS_SVH
`define MITC_CLK_PER_ICYC 4
`define MITC_PC_W 13
`define MITC_STACK_DEPTH 8
`define MITC_PC_RST 13'h0000
// Opcode layout: [15:12] class, [11:8] sub, [7:0] operand/immediate
`define MITC_OP_HI 15
`define MITC_OP_LO 12
`define MITC_SUB_HI 11
`define MITC_SUB_LO 8
`define MITC_DST_BIT 11
`define MITC_TGT_HI 12
`endif

// ==== mitc_pkg.sv ====
// Purpose: types for the instruction timing core
// Assumes: opcode classes as encoded in instr[15:12]
// Notes: none
package mitc_pkg;
  typedef enum logic [3:0] {
    MITC_OP_NOP, MITC_OP_ADD, MITC_OP_SUB, MITC_OP_AND, MITC_OP_OR, MITC_OP_XOR,
    MITC_OP_INVERT, MITC_OP_INC, MITC_OP_MINUS1, MITC_OP_ROT, MITC_OP_SZ, MITC_OP_SBIT,
    MITC_OP_BRANCH, MITC_OP_CALL, MITC_OP_EXIT, MITC_OP_TBL
  } mitc_op_e;
  typedef enum logic [1:0] {MITC_ST_FETCH, MITC_ST_EXEC, MITC_ST_EXTRA} mitc_st_e;
endpackage

// ==== mitc_core.sv ====
// Summary of operation
// - Most instructions one cycle; branch, call, return, table read take two.
// - Each instruction cycle is exactly four system clock periods.
// - Writing program counter low byte jumps there and costs one extra cycle.
// - Taken skip costs one extra cycle; untaken skip costs one.
// - Logical operations set zero flag when result is zero.
// - Return resumes at address right after the entering call.
// - Add sets carry above 255; subtract clears carry below zero (carry is not-borrow).
// - Increment and decrement change the operand by exactly one.
// - Rotates shift one bit; through-carry forms rotate via carry.
// - Conditional skips test memory value or bit, then run or skip next.
// - Unconditional jump moves to target without saving return address.
// Purpose: execution and timing of an 8-bit core
// Assumes: program word and operand byte valid during the instruction cycle
// Notes: instr[11] selects result to memory (1) or accumulator (0)
`timescale 1ns/1ns
`include "mitc_defs.svh"
module mitc_core
  import mitc_pkg::*;
#(
  parameter int PC_W = `MITC_PC_W,
  parameter int DEPTH = `MITC_STACK_DEPTH
)(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [15:0] instr,
  input wire logic [7:0] mem_rdata,
  input wire logic pc_low_wr,
  output logic [PC_W-1:0] pc_q,
  output logic [7:0] acc_q,
  output logic [7:0] mem_wdata_q,
  output logic mem_we_q,
  output logic zero_q,
  output logic carry_q,
  output logic icyc_q,
  output logic busy_extra_q,
  output logic stack_err_q
);
  // ==========================================
  // Instruction cycle divider
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  wire icyc_end = (phase_q == 2'(`MITC_CLK_PER_ICYC - 1));
  assign phase_d = icyc_end ? 2'h0 : phase_q + 2'h1;

  // ==========================================
  // Decode
  wire mitc_op_e op = mitc_op_e'(instr[`MITC_OP_HI:`MITC_OP_LO]);
  wire [3:0] sub = instr[`MITC_SUB_HI:`MITC_SUB_LO];
  wire [7:0] imm = instr[7:0];
  wire to_mem = instr[`MITC_DST_BIT];
  wire [PC_W-1:0] tgt = instr[PC_W-1:0];
  wire [7:0] opnd = sub[2] ? imm : mem_rdata;
  wire [PC_W-1:0] pc_next = pc_q + PC_W'(1);

  // ==========================================
  // Datapath
  wire use_c = sub[0];
  wire [8:0] add_r = {1'b0, acc_q} + {1'b0, opnd} + {8'h00, use_c & carry_q};
  wire [8:0] sub_r = {1'b0, acc_q} - {1'b0, opnd} - {8'h00, use_c & ~carry_q};
  wire [7:0] inc_r = mem_rdata + 8'h01;
  wire [7:0] minus_r = mem_rdata - 8'h01;
  wire [7:0] rot_r;
  wire rot_c;
  // sub[1]: left, sub[0]: through carry
  assign rot_r = sub[1] ? {mem_rdata[6:0], sub[0] ? carry_q : mem_rdata[7]}
                        : {sub[0] ? carry_q : mem_rdata[0], mem_rdata[7:1]};
  assign rot_c = sub[1] ? mem_rdata[7] : mem_rdata[0];

  logic [7:0] res;
  logic res_valid;
  always_comb
  begin
    res = 8'h00;
    res_valid = 1'b1;
    case (op)
      MITC_OP_ADD: res = add_r[7:0];
      MITC_OP_SUB: res = sub_r[7:0];
      MITC_OP_AND: res = acc_q & opnd;
      MITC_OP_OR: res = acc_q | opnd;
      MITC_OP_XOR: res = acc_q ^ opnd;
      MITC_OP_INVERT: res = ~mem_rdata;
      MITC_OP_INC: res = inc_r;
      MITC_OP_MINUS1: res = minus_r;
      MITC_OP_ROT: res = rot_r;
      default: res_valid = 1'b0;
    endcase
  end
  wire logic_op = (op == MITC_OP_AND) || (op == MITC_OP_OR) || (op == MITC_OP_XOR) ||
                  (op == MITC_OP_INVERT);
  wire sets_z = logic_op || (op == MITC_OP_ADD) || (op == MITC_OP_SUB) ||
                (op == MITC_OP_INC) || (op == MITC_OP_MINUS1);
  // Skip tests: zero after inc/dec/test, or nonzero, by sub[1:0]; or bit by sub[2:0]
  logic skip_sz;
  always_comb
  begin
    case (sub[1:0])
      2'h0: skip_sz = (mem_rdata == 8'h00);
      2'h1: skip_sz = (inc_r == 8'h00);
      2'h2: skip_sz = (minus_r == 8'h00);
      default: skip_sz = (mem_rdata != 8'h00);
    endcase
  end
  wire skip_bit = (mem_rdata[sub[2:0]] == sub[3]);
  wire skip_take = (op == MITC_OP_SZ) ? skip_sz : (op == MITC_OP_SBIT) ? skip_bit : 1'b0;
  wire sz_wr = (op == MITC_OP_SZ) && (sub[1:0] == 2'h1 || sub[1:0] == 2'h2) && to_mem;

  // ==========================================
  // Return stack
  logic [PC_W-1:0] stack_q [DEPTH];
  logic [$clog2(DEPTH):0] sp_q;
  wire do_call = icyc_end && !busy_extra_q && (op == MITC_OP_CALL);
  wire do_exit = icyc_end && !busy_extra_q && (op == MITC_OP_EXIT);
  wire [PC_W-1:0] exit_addr = stack_q[sp_q[$clog2(DEPTH)-1:0] - 1'b1];
  // Overflow wraps the oldest entry; flagged, not blocked
  always_ff @(posedge clk_sys)
  begin
    if (do_call)
      stack_q[sp_q[$clog2(DEPTH)-1:0]] <= pc_next;
  end

  // ==========================================
  // Sequencing
  wire two_cyc = (op == MITC_OP_BRANCH) || (op == MITC_OP_CALL) || (op == MITC_OP_EXIT) ||
                 (op == MITC_OP_TBL) || pc_low_wr || skip_take;
  logic [PC_W-1:0] pc_d;
  always_comb
  begin
    pc_d = pc_q;
    if (icyc_end && !busy_extra_q)
    begin
      case (op)
        MITC_OP_BRANCH: pc_d = tgt;
        MITC_OP_CALL: pc_d = tgt;
        MITC_OP_EXIT: pc_d = exit_addr;
        default: pc_d = pc_low_wr ? {pc_q[PC_W-1:8], res}
                                  : skip_take ? pc_q + PC_W'(2) : pc_next;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      phase_q <= 2'h0;
      pc_q <= `MITC_PC_RST;
      acc_q <= 8'h00;
      mem_wdata_q <= 8'h00;
      mem_we_q <= 1'b0;
      zero_q <= 1'b0;
      carry_q <= 1'b0;
      icyc_q <= 1'b0;
      busy_extra_q <= 1'b0;
      sp_q <= '0;
      stack_err_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      icyc_q <= icyc_end;
      mem_we_q <= 1'b0;
      pc_q <= pc_d;
      if (icyc_end && busy_extra_q)
        busy_extra_q <= 1'b0;
      else if (icyc_end)
      begin
        busy_extra_q <= two_cyc;
        if (res_valid && (to_mem || pc_low_wr))
        begin
          mem_wdata_q <= res;
          mem_we_q <= 1'b1;
        end
        else if (res_valid)
          acc_q <= res;
        if (sz_wr)
        begin
          mem_wdata_q <= (sub[1:0] == 2'h1) ? inc_r : minus_r;
          mem_we_q <= 1'b1;
        end
        if (sets_z)
          zero_q <= (res == 8'h00);
        if (op == MITC_OP_ADD)
          carry_q <= add_r[8];
        else if (op == MITC_OP_SUB)
          carry_q <= ~sub_r[8];
        else if (op == MITC_OP_ROT && sub[0])
          carry_q <= rot_c;
        if (do_call)
        begin
          sp_q <= (sp_q == DEPTH[$clog2(DEPTH):0]) ? sp_q : sp_q + 1'b1;
          if (sp_q == DEPTH[$clog2(DEPTH):0])
            stack_err_q <= 1'b1;
        end
        else if (do_exit)
        begin
          if (sp_q == '0)
            stack_err_q <= 1'b1;
          else
            sp_q <= sp_q - 1'b1;
        end
      end
    end
  end

  // ==========================================
  // Checks
  property p_icyc_period;
    @(posedge clk_sys) disable iff (srst) icyc_q |=> !icyc_q [*3] ##1 icyc_q;
  endproperty
  a_icyc_period: assert property (p_icyc_period) else $error("cycle not 4 clocks");

  property p_branch_extra;
    @(posedge clk_sys) disable iff (srst)
      (icyc_end && !busy_extra_q && op == MITC_OP_BRANCH) |=> busy_extra_q && pc_q == $past(tgt);
  endproperty
  a_branch_extra: assert property (p_branch_extra) else $error("jump wrong");

  property p_call_push;
    @(posedge clk_sys) disable iff (srst)
      (do_call && sp_q < DEPTH) |=> sp_q == $past(sp_q) + 1'b1;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call did not push");

  property p_exit_pc;
    @(posedge clk_sys) disable iff (srst) (do_exit && sp_q != '0) |=> pc_q == $past(exit_addr);
  endproperty
  a_exit_pc: assert property (p_exit_pc) else $error("return address wrong");

  property p_skip;
    @(posedge clk_sys) disable iff (srst)
      (icyc_end && !busy_extra_q && skip_take && !pc_low_wr)
        |=> busy_extra_q && pc_q == $past(pc_q) + PC_W'(2);
  endproperty
  a_skip: assert property (p_skip) else $error("skip timing wrong");

  property p_noskip;
    @(posedge clk_sys) disable iff (srst)
      (icyc_end && !busy_extra_q && (op == MITC_OP_SZ) && !skip_take && !pc_low_wr)
        |=> !busy_extra_q;
  endproperty
  a_noskip: assert property (p_noskip) else $error("untaken skip too long");

  property p_pc_low;
    @(posedge clk_sys) disable iff (srst)
      (icyc_end && !busy_extra_q && pc_low_wr && res_valid)
        |=> busy_extra_q && pc_q[7:0] == $past(res) &&
            pc_q[PC_W-1:8] == $past(pc_q[PC_W-1:8]);
  endproperty
  a_pc_low: assert property (p_pc_low) else $error("low byte write no jump");

  property p_zero;
    @(posedge clk_sys) disable iff (srst)
      (icyc_end && !busy_extra_q && logic_op) |=> zero_q == ($past(res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_add_c;
    @(posedge clk_sys) disable iff (srst)
      (icyc_end && !busy_extra_q && op == MITC_OP_ADD) |=> carry_q == $past(add_r[8]);
  endproperty
  a_add_c: assert property (p_add_c) else $error("carry wrong");

  property p_inc;
    @(posedge clk_sys) disable iff (srst)
      (icyc_end && !busy_extra_q && op == MITC_OP_INC && !to_mem && !pc_low_wr)
        |=> acc_q == $past(mem_rdata) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");

  property p_rot;
    @(posedge clk_sys) disable iff (srst)
      (icyc_end && !busy_extra_q && op == MITC_OP_ROT && sub[1:0] == 2'h3 && !to_mem)
        |=> carry_q == $past(mem_rdata[7]) && acc_q[0] == $past(carry_q);
  endproperty
  a_rot: assert property (p_rot) else $error("rotate wrong");

  // Extra cycle must last one whole instruction cycle, then free
  sequence s_issue_two;
    icyc_end && !busy_extra_q && two_cyc;
  endsequence
  sequence s_extra_span;
    busy_extra_q [*4] ##1 !busy_extra_q;
  endsequence
  property p_two_cyc;
    @(posedge clk_sys) disable iff (srst) s_issue_two |=> s_extra_span;
  endproperty
  a_two_cyc: assert property (p_two_cyc) else $error("extra cycle length wrong");

  property p_one_cyc;
    @(posedge clk_sys) disable iff (srst)
      (icyc_end && !busy_extra_q && !two_cyc)
        |=> !busy_extra_q && pc_q == $past(pc_q) + PC_W'(1);
  endproperty
  a_one_cyc: assert property (p_one_cyc) else $error("single cycle wrong");

  property p_sub_c;
    @(posedge clk_sys) disable iff (srst)
      (icyc_end && !busy_extra_q && op == MITC_OP_SUB && !use_c)
        |=> carry_q == ($past(acc_q) >= $past(opnd));
  endproperty
  a_sub_c: assert property (p_sub_c) else $error("borrow wrong");

  property p_branch_nopush;
    @(posedge clk_sys) disable iff (srst)
      (icyc_end && !busy_extra_q && op == MITC_OP_BRANCH) |=> sp_q == $past(sp_q);
  endproperty
  a_branch_nopush: assert property (p_branch_nopush) else $error("jump pushed");

  property p_minus1;
    @(posedge clk_sys) disable iff (srst)
      (icyc_end && !busy_extra_q && op == MITC_OP_MINUS1 && !to_mem && !pc_low_wr)
        |=> acc_q == $past(mem_rdata) - 8'h01;
  endproperty
  a_minus1: assert property (p_minus1) else $error("decrement wrong");
endmodule

// ==== mitc_mem_model.sv ====
// Purpose: program and data memory seen by the core
// Assumes: reads follow pc_q and the operand field
// Notes: filler word everywhere, so a stray fetch shows up in acc
`timescale 1ns/1ns
module mitc_mem_model
  import mitc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [12:0] pc_q,
  input wire logic [7:0] mem_wdata_q,
  input wire logic mem_we_q,
  output logic [15:0] instr,
  output logic [7:0] mem_rdata,
  output logic pc_low_wr
);
  logic [15:0] prog [0:8191];
  logic pclw [0:8191];
  logic [7:0] dmem [0:255];
  logic [7:0] addr_q;
  logic [12:0] pa;
  initial
  begin
    for (int i = 0; i < 8192; i++)
    begin
      prog[i] = {MITC_OP_ADD, 4'h4, 8'h11};
      pclw[i] = 1'b0;
    end
    for (int i = 0; i < 256; i++)
      dmem[i] = 8'(i);
  end
  // Before the first reset edge pc is unknown
  assign pa = $isunknown(pc_q) ? 13'h0000 : pc_q;
  // Same small delay as the bench drivers
  assign #10 instr = prog[pa];
  assign #10 pc_low_wr = pclw[pa];
  assign #10 mem_rdata = dmem[instr[7:0]];
  always @(posedge clk_sys)
  begin
    if (mem_we_q === 1'b1)
      dmem[addr_q] <= mem_wdata_q;
    addr_q <= instr[7:0];
  end
endmodule

// ==== tb_mitc_core.sv ====
// Purpose: self-checking bench for the instruction timing core
// Assumes: program is loaded into the memory model during reset
// Notes: one note per retired instruction, checked at its last icyc pulse
`timescale 1ns/1ns
module tb_mitc_core
  import mitc_pkg::*;
;
  logic clk_sys;
  logic srst;
  logic [15:0] instr;
  logic [7:0] mem_rdata;
  logic pc_low_wr;
  logic [12:0] pc_q;
  logic [7:0] acc_q;
  logic [7:0] mem_wdata_q;
  logic mem_we_q;
  logic zero_q;
  logic carry_q;
  logic icyc_q;
  logic busy_extra_q;
  logic stack_err_q;
  int n_errors;
  int checked;
  int gap;
  bit seen;
  logic [29:0] notes [$];
  logic [29:0] nt;
  logic [7:0] ea;
  logic [7:0] r2;
  logic [7:0] r3;
  logic ez;
  logic ec;
  mitc_core u_mitc_core (.clk_sys(clk_sys), .srst(srst), .instr(instr),
    .mem_rdata(mem_rdata), .pc_low_wr(pc_low_wr), .pc_q(pc_q), .acc_q(acc_q),
    .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q), .zero_q(zero_q), .carry_q(carry_q),
    .icyc_q(icyc_q), .busy_extra_q(busy_extra_q), .stack_err_q(stack_err_q));
  mitc_mem_model u_mem (.clk_sys(clk_sys), .pc_q(pc_q), .mem_wdata_q(mem_wdata_q),
    .mem_we_q(mem_we_q), .instr(instr), .mem_rdata(mem_rdata), .pc_low_wr(pc_low_wr));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Note layout: mask acc/zero/carry, clocks, carry, zero, acc, pc
  task automatic put(input logic [12:0] a, input logic [15:0] ins, input logic w,
    input logic [12:0] np, input logic [3:0] cy, input logic [2:0] mk);
    u_mem.prog[a] = ins;
    u_mem.pclw[a] = w;
    notes.push_back({mk, cy, ec, ez, ea, np});
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // Result watcher
  always @(negedge clk_sys)
  begin
    gap++;
    if (icyc_q === 1'b1 && busy_extra_q === 1'b0 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      chk("pc", nt[12:0], pc_q);
      if (nt[29]) chk("acc", {5'h00, nt[20:13]}, {5'h00, acc_q});
      if (nt[28]) chk("zero", {12'h000, nt[21]}, {12'h000, zero_q});
      if (nt[27]) chk("carry", {12'h000, nt[22]}, {12'h000, carry_q});
      if (seen) chk("clocks", {9'h000, nt[26:23]}, 13'(gap));
      seen = 1'b1;
      gap = 0;
    end
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    $display("[FAIL] run expected done seen hang");
    final_report();
  end
  // ==========================================
  // Program with expected results
  initial
  begin
    n_errors = 0;
    checked = 0;
    gap = 0;
    seen = 1'b0;
    srst = 1'b1;
    void'($urandom(32'hB6BE80CE));
    @(posedge clk_sys);
    ez = 1'b0;
    ec = 1'b0;
    ea = 8'($urandom());
    r2 = 8'($urandom());
    r3 = 8'($urandom());
    put(13'h0000, {MITC_OP_ADD, 4'h4, ea}, 1'b0, 13'h0001, 4'h4, 3'b101);
    {ec, ea} = {1'b0, ea} + {1'b0, r2};
    put(13'h0001, {MITC_OP_ADD, 4'h4, r2}, 1'b0, 13'h0002, 4'h4, 3'b101);
    ec = (ea >= r3);
    ea = ea - r3;
    put(13'h0002, {MITC_OP_SUB, 4'h4, r3}, 1'b0, 13'h0003, 4'h4, 3'b101);
    ea = {ec, 7'h40};
    ec = 1'b1;
    put(13'h0003, {MITC_OP_ROT, 4'h1, 8'h81}, 1'b0, 13'h0004, 4'h4, 3'b101);
    ea = 8'h01;
    put(13'h0004, {MITC_OP_ROT, 4'h3, 8'h80}, 1'b0, 13'h0005, 4'h4, 3'b101);
    ea = 8'hC0;
    put(13'h0005, {MITC_OP_ROT, 4'h0, 8'h81}, 1'b0, 13'h0006, 4'h4, 3'b100);
    ea = 8'h03;
    put(13'h0006, {MITC_OP_ROT, 4'h2, 8'h81}, 1'b0, 13'h0007, 4'h4, 3'b100);
    ea = 8'h00;
    ez = 1'b1;
    put(13'h0007, {MITC_OP_AND, 4'h0, 8'h00}, 1'b0, 13'h0008, 4'h4, 3'b110);
    ea = 8'h5A;
    ez = 1'b0;
    put(13'h0008, {MITC_OP_XOR, 4'h0, 8'h5A}, 1'b0, 13'h0009, 4'h4, 3'b110);
    ea = 8'hDB;
    put(13'h0009, {MITC_OP_OR, 4'h0, 8'h81}, 1'b0, 13'h000A, 4'h4, 3'b110);
    ea = 8'h00;
    ez = 1'b1;
    put(13'h000A, {MITC_OP_INVERT, 4'h0, 8'hFF}, 1'b0, 13'h000B, 4'h4, 3'b110);
    ea = 8'h80;
    put(13'h000B, {MITC_OP_INC, 4'h0, 8'h7F}, 1'b0, 13'h000C, 4'h4, 3'b100);
    ea = 8'hFF;
    put(13'h000C, {MITC_OP_MINUS1, 4'h0, 8'h00}, 1'b0, 13'h000D, 4'h4, 3'b100);
    put(13'h000D, {MITC_OP_SZ, 4'h0, 8'h00}, 1'b0, 13'h000F, 4'h8, 3'b000);
    put(13'h000F, {MITC_OP_SZ, 4'h3, 8'h00}, 1'b0, 13'h0010, 4'h4, 3'b000);
    put(13'h0010, {MITC_OP_SBIT, 4'h8, 8'h01}, 1'b0, 13'h0012, 4'h8, 3'b000);
    put(13'h0012, {MITC_OP_SBIT, 4'h0, 8'h01}, 1'b0, 13'h0013, 4'h4, 3'b000);
    put(13'h0013, {MITC_OP_TBL, 12'h000}, 1'b0, 13'h0014, 4'h8, 3'b000);
    put(13'h0014, {MITC_OP_BRANCH, 12'h100}, 1'b0, 13'h0100, 4'h8, 3'b000);
    put(13'h0100, {MITC_OP_CALL, 12'h200}, 1'b0, 13'h1200, 4'h8, 3'b000);
    // In-place increment, read back through acc to prove the write landed
    put(13'h1200, {MITC_OP_INC, 4'h8, 8'h30}, 1'b0, 13'h1201, 4'h4, 3'b000);
    ea = 8'h32;
    put(13'h1201, {MITC_OP_INC, 4'h0, 8'h30}, 1'b0, 13'h1202, 4'h4, 3'b100);
    put(13'h1202, {MITC_OP_EXIT, 12'h000}, 1'b0, 13'h0101, 4'h8, 3'b000);
    put(13'h0101, {MITC_OP_ROT, 4'h2, 8'h20}, 1'b1, 13'h0140, 4'h8, 3'b000);
    // Return with nothing stacked, unless the jump wrongly pushed
    u_mem.prog[13'h0140] = {MITC_OP_EXIT, 12'h000};
    repeat (4) @(posedge clk_sys);
    #10 srst = 1'b0;
    for (int i = 0; i < 400 && notes.size() > 0; i++) @(posedge clk_sys);
    repeat (40) @(posedge clk_sys);
    chk("pending", 13'h0000, 13'(notes.size()));
    chk("stack_err", 13'h0001, {12'h000, stack_err_q});
    chk("mem_wdata", 13'h0040, {5'h00, mem_wdata_q});
    final_report();
  end
endmodule
